// ---- src/wrs_pkg.sv ----
// constants, register map and state layout for the watchdog and reset-cause block
package wrs_pkg;

	// register map, byte offsets on the plain register port
	localparam logic [7:0] WRS_CTRL_ADDR   = 8'h21;
	localparam logic [7:0] WRS_STATUS_ADDR = 8'h22;

	// control register field positions
	localparam int WRS_CTRL_IRQ_FLAG = 7;
	localparam int WRS_CTRL_IRQ_EN   = 6;
	localparam int WRS_CTRL_PS3      = 5;
	localparam int WRS_CTRL_CHG_EN   = 4;
	localparam int WRS_CTRL_WD_EN    = 3;

	// status register field positions, bits 7..4 read as zero
	localparam int WRS_ST_WATCHDOG_RESET_FLAG = 3;
	localparam int WRS_ST_BROWNOUT_RESET_FLAG = 2;
	localparam int WRS_ST_EXTF = 1;
	localparam int WRS_ST_POWERON_RESET_FLAG = 0;

	// synchroniser lanes for the asynchronous inputs
	localparam int WRS_SY_POR  = 0;
	localparam int WRS_SY_BOR  = 1;
	localparam int WRS_SY_EXT  = 2;
	localparam int WRS_SY_OSC  = 3;
	localparam int WRS_SY_FUSE = 4;
	localparam int WRS_SY_W    = 5;

	// watchdog oscillator and period selection
	localparam int          WRS_OSC_HZ      = 128000;
	localparam logic [20:0] WRS_BASE_CYCLES = 21'h000800;
	localparam logic [3:0]  WRS_PS_MAX      = 4'h9;

	// change-enable window, in system clock cycles
	localparam logic [2:0] WRS_CHG_WINDOW = 3'h4;

	typedef struct packed {
		logic [WRS_SY_W-1:0] sync1;
		logic [WRS_SY_W-1:0] sync2;
		logic                osc_prev;
		logic [19:0]         wdt_cnt;
		logic                timeout_irq_flag;
		logic                timeout_irq_enable;
		logic [3:0]          ps;
		logic                change_enable;
		logic [2:0]          ce_cnt;
		logic                watchdog_enable;
		logic                watchdog_reset_flag;
		logic                brownout_reset_flag;
		logic                external_reset_flag;
		logic                poweron_reset_flag;
		logic                rst_pulse;
		logic                dly_start;
		logic [7:0]          rdata;
	} wrs_state_t;

	// reset value: a block reset is a power-up, so the power-on flag starts set
	localparam wrs_state_t WRS_RESET = '{poweron_reset_flag: 1'b1, default: '0};

endpackage : wrs_pkg

// ---- src/wrs_watchdog.sv ----
// watchdog timer with safety levels, timed change sequence and reset-cause flags
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - timeout in reset mode gives one-cycle pulse
// - startup delay starts at pulse falling edge
// - status bits seven to four read zero
// - watchdog flag set by reset, cleared by POR/software
// - brownout flag set by brownout, cleared likewise
// - external flag set by pin reset, cleared likewise
// - poweron flag cleared only by software zero
// - counter ticks from separate 128 kHz oscillator
// - counter clears on restart, disable, chip reset
// - ten selectable timeout periods
// - fuse picks safety level one or two
// - timeout sets interrupt flag in interrupt mode
// - flag cleared by vector ack or write one
// - interrupt needs global enable and irq or watchdog enable
// - enable pair selects stop, irq, reset, irq-first
// - timeout clears irq enable while enable set
// - change enable self-clears after four cycles
// - disable, or level-two period change, needs change enable
// - level two keeps watchdog always enabled
// - level one: watchdog flag forces enable on
// - codes 0..9 give 2048 doubling cycles
// - level two second write ignores enable bit
module wrs_watchdog
	import wrs_pkg::*;
(
	input  wire logic       SYS_CLK,
	input  wire logic       RST_N,
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	input  wire logic       WDT_OSC,
	input  wire logic       POR_DET,
	input  wire logic       BOR_DET,
	input  wire logic       EXT_RST_DET,
	input  wire logic       SAFETY_FUSE_PROG,
	input  wire logic       WDT_RESTART,
	input  wire logic       IRQ_ACK,
	input  wire logic       GLOBAL_IRQ_EN,
	output logic            WDT_RESET,
	output logic            DELAY_START,
	output logic            TIMEOUT_IRQ
);

	// last count before wrap for a period code; reserved codes fall back to the shortest
	function automatic logic [19:0] wrs_last(input logic [3:0] ps);
		logic [20:0] full;
		full = (ps > WRS_PS_MAX) ? WRS_BASE_CYCLES : (WRS_BASE_CYCLES << ps);
		return full[19:0] - 20'h00001;
	endfunction : wrs_last

	wrs_state_t q;
	wrs_state_t d;

	logic lvl2;
	logic por_lvl;
	logic bor_lvl;
	logic ext_lvl;
	logic osc_tick;
	logic wde_eff;
	logic running;
	logic hit;
	logic chip_rst;
	logic ctrl_wr;
	logic st_wr;
	logic open_seq;

	// decoded views of the synchronised inputs and the current state
	always_comb begin
		lvl2     = q.sync2[WRS_SY_FUSE];
		por_lvl  = q.sync2[WRS_SY_POR];
		bor_lvl  = q.sync2[WRS_SY_BOR];
		ext_lvl  = q.sync2[WRS_SY_EXT];
		osc_tick = q.sync2[WRS_SY_OSC] & ~q.osc_prev;
		wde_eff  = q.watchdog_enable | lvl2 | q.watchdog_reset_flag;
		running  = wde_eff | q.timeout_irq_enable;
		hit      = running & osc_tick & (q.wdt_cnt == wrs_last(q.ps));
		chip_rst = por_lvl | bor_lvl | ext_lvl | q.rst_pulse;
		ctrl_wr  = WR & (ADDR == WRS_CTRL_ADDR);
		st_wr    = WR & (ADDR == WRS_STATUS_ADDR);
		open_seq = WDATA[WRS_CTRL_CHG_EN] & WDATA[WRS_CTRL_WD_EN];
	end

	// next-state logic; hardware sets are applied after software clears so they win
	always_comb begin
		d = q;

		// two flops per asynchronous input; only sync2 feeds logic
		d.sync1    = {SAFETY_FUSE_PROG, WDT_OSC, EXT_RST_DET, BOR_DET, POR_DET};
		d.sync2    = q.sync1;
		d.osc_prev = q.sync2[WRS_SY_OSC];

		// counter: cleared when stopped or restarted, wraps on the last count
		if (chip_rst || WDT_RESTART || !running) begin
			d.wdt_cnt = 20'h00000;
		end else if (osc_tick) begin
			d.wdt_cnt = hit ? 20'h00000 : q.wdt_cnt + 20'h00001;
		end

		// change-enable window runs down on the system clock
		if (q.change_enable) begin
			d.ce_cnt = q.ce_cnt - 3'h1;
			if (q.ce_cnt == 3'h1) begin
				d.change_enable = 1'b0;
			end
		end

		// control register write
		if (ctrl_wr) begin
			if (WDATA[WRS_CTRL_IRQ_FLAG]) begin
				d.timeout_irq_flag = 1'b0;
			end
			d.timeout_irq_enable = WDATA[WRS_CTRL_IRQ_EN];
			// a re-open inside the window does not stretch it
			if (open_seq && !q.change_enable) begin
				d.change_enable   = 1'b1;
				d.ce_cnt = WRS_CHG_WINDOW;
			end
			if (WDATA[WRS_CTRL_WD_EN]) begin
				d.watchdog_enable = 1'b1;
			end else if (q.change_enable && !lvl2 && !q.watchdog_reset_flag) begin
				d.watchdog_enable = 1'b0;
			end
			// period is free at level one, guarded at level two
			if (!lvl2 || q.change_enable) begin
				d.ps = {WDATA[WRS_CTRL_PS3], WDATA[2:0]};
			end
		end

		// vector taken clears the flag
		if (IRQ_ACK) begin
			d.timeout_irq_flag = 1'b0;
		end

		// status register write: a zero clears, a one leaves the flag alone
		if (st_wr) begin
			d.watchdog_reset_flag  = q.watchdog_reset_flag  & WDATA[WRS_ST_WATCHDOG_RESET_FLAG];
			d.brownout_reset_flag  = q.brownout_reset_flag  & WDATA[WRS_ST_BROWNOUT_RESET_FLAG];
			d.external_reset_flag = q.external_reset_flag & WDATA[WRS_ST_EXTF];
			d.poweron_reset_flag  = q.poweron_reset_flag  & WDATA[WRS_ST_POWERON_RESET_FLAG];
		end

		// time-out action chosen by the enable pair
		d.rst_pulse = 1'b0;
		if (hit) begin
			if (q.timeout_irq_enable) begin
				d.timeout_irq_flag = 1'b1;
				if (wde_eff) begin
					d.timeout_irq_enable = 1'b0;
				end
			end else begin
				d.rst_pulse = 1'b1;
			end
		end
		// the delay timer starts when the pulse drops
		d.dly_start = q.rst_pulse;

		// any chip reset returns control to its initial state
		if (chip_rst) begin
			d.timeout_irq_flag   = 1'b0;
			d.timeout_irq_enable   = 1'b0;
			d.ps     = 4'h0;
			d.change_enable   = 1'b0;
			d.ce_cnt = 3'h0;
			d.watchdog_enable    = 1'b0;
			d.rst_pulse = 1'b0;
		end
		// reset-cause flags; a power-on wipes the others, never itself
		if (q.rst_pulse) begin
			d.watchdog_reset_flag = 1'b1;
		end
		if (bor_lvl) begin
			d.brownout_reset_flag = 1'b1;
		end
		if (ext_lvl) begin
			d.external_reset_flag = 1'b1;
		end
		if (por_lvl) begin
			d.watchdog_reset_flag  = 1'b0;
			d.brownout_reset_flag  = 1'b0;
			d.external_reset_flag = 1'b0;
			d.poweron_reset_flag  = 1'b1;
		end

		// read data stand one cycle after the strobe, zero otherwise
		d.rdata = 8'h00;
		if (RD) begin
			if (ADDR == WRS_CTRL_ADDR) begin
				d.rdata = {q.timeout_irq_flag, q.timeout_irq_enable, q.ps[3], q.change_enable, wde_eff, q.ps[2:0]};
			end else if (ADDR == WRS_STATUS_ADDR) begin
				d.rdata = {4'h0, q.watchdog_reset_flag, q.brownout_reset_flag, q.external_reset_flag, q.poweron_reset_flag};
			end
		end
	end

	// single state register, synchronous active-low reset
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			q <= WRS_RESET;
		end else begin
			q <= d;
		end
	end

	// outputs
	assign RDATA       = q.rdata;
	assign WDT_RESET   = q.rst_pulse;
	assign DELAY_START = q.dly_start;
	// in interrupt-first mode the same time-out that raises the flag drops the enable,
	// so a flag raised with the watchdog enabled still asks for service until acked
	assign TIMEOUT_IRQ = q.timeout_irq_flag & (q.timeout_irq_enable | wde_eff) & GLOBAL_IRQ_EN;

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	chk_pulse_one_cycle: assert property (q.rst_pulse |=> !q.rst_pulse)
		else $error("watchdog reset pulse longer than one cycle");
	chk_delay_after_fall: assert property ($fell(q.rst_pulse) |-> q.dly_start)
		else $error("delay start missing at pulse falling edge");
	chk_status_reserved: assert property (RD && ADDR == WRS_STATUS_ADDR |=> RDATA[7:4] == 4'h0)
		else $error("reserved status bits read nonzero");
	chk_watchdog_reset_flag_on_pulse: assert property (q.rst_pulse && !por_lvl |=> q.watchdog_reset_flag)
		else $error("watchdog flag not set after watchdog reset");
	chk_poweron_reset_flag_on_por: assert property (por_lvl |=> q.poweron_reset_flag && !q.watchdog_reset_flag && !q.brownout_reset_flag)
		else $error("power-on flags wrong after power-on reset");
	chk_cnt_restart: assert property (WDT_RESTART |=> q.wdt_cnt == 20'h00000)
		else $error("counter not cleared by restart");
	chk_irq_flag_set: assert property (hit && q.timeout_irq_enable |=> q.timeout_irq_flag || chip_rst)
		else $error("interrupt flag not set on timeout");
	chk_irq_flag_ack: assert property (IRQ_ACK && !hit && !chip_rst |=> !q.timeout_irq_flag)
		else $error("interrupt flag not cleared by vector ack");
	chk_reset_mode: assert property (hit && !q.timeout_irq_enable && !chip_rst |=> q.rst_pulse ##1 q.dly_start)
		else $error("reset mode timeout gave no pulse");
	chk_timeout_irq_enable_autoclr: assert property (hit && q.timeout_irq_enable && wde_eff |=> !q.timeout_irq_enable)
		else $error("irq enable not cleared on timeout");
	chk_ce_window: assert property (disable iff (!RST_N || chip_rst)
		$rose(q.change_enable) |-> q.change_enable[*4] ##1 !q.change_enable)
		else $error("change enable window is not four cycles");
	chk_disable_guard: assert property ($fell(q.watchdog_enable) && !$past(chip_rst) |-> $past(q.change_enable))
		else $error("watchdog disabled without change enable");
	chk_level2_on: assert property (lvl2 |-> wde_eff)
		else $error("level two watchdog reads disabled");
	chk_watchdog_reset_flag_forces: assert property (q.watchdog_reset_flag |-> wde_eff)
		else $error("watchdog flag set but enable clear");

	// cause flags raised by their own detector unless a power-on wipes them
	chk_brownout_reset_flag_on_bor: assert property (bor_lvl && !por_lvl |=> q.brownout_reset_flag)
		else $error("brownout flag not set after brownout reset");
	chk_external_reset_flag_on_ext: assert property (ext_lvl && !por_lvl |=> q.external_reset_flag)
		else $error("external flag not set after pin reset");
	chk_poweron_reset_flag_sw_clear: assert property (st_wr && !WDATA[WRS_ST_POWERON_RESET_FLAG] && !por_lvl |=> !q.poweron_reset_flag)
		else $error("power-on flag not cleared by software zero");

	// software write of one drops the interrupt flag unless a time-out lands at once
	chk_irq_flag_wr1: assert property (ctrl_wr && WDATA[WRS_CTRL_IRQ_FLAG] && !hit |=> !q.timeout_irq_flag)
		else $error("interrupt flag not cleared by write one");
	chk_irq_gating: assert property (TIMEOUT_IRQ |-> GLOBAL_IRQ_EN && q.timeout_irq_flag)
		else $error("interrupt raised without global enable and flag");

	// counter behaviour: held between ticks, one step per tick, zero when stopped or wrapped
	chk_cnt_stopped: assert property (!running |=> q.wdt_cnt == 20'h00000)
		else $error("counter not cleared while stopped");
	chk_cnt_hold: assert property (running && !osc_tick && !chip_rst && !WDT_RESTART
		|=> $stable(q.wdt_cnt))
		else $error("counter moved without an oscillator tick");
	chk_cnt_step: assert property (running && osc_tick && !hit && !chip_rst && !WDT_RESTART
		|=> q.wdt_cnt == $past(q.wdt_cnt) + 20'h00001)
		else $error("counter did not step on oscillator tick");
	chk_cnt_wrap: assert property (hit && !chip_rst && !WDT_RESTART |=> q.wdt_cnt == 20'h00000)
		else $error("counter did not wrap at selected count");

	// level two leaves the period alone outside the change window
	chk_ps_guard_l2: assert property (lvl2 && ctrl_wr && !q.change_enable && !chip_rst |=> $stable(q.ps))
		else $error("level two period changed outside window");
	chk_dly_one: assert property (q.dly_start |=> !q.dly_start)
		else $error("delay start longer than one cycle");
	chk_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
		else $error("read data standing without a read strobe");

	cov_reset_pulse: cover property (q.rst_pulse ##1 q.dly_start);
	cov_irq_taken:   cover property (TIMEOUT_IRQ ##[1:20] IRQ_ACK);
	cov_disable_seq: cover property (q.change_enable ##[1:4] $fell(wde_eff));
	cov_lvl2_change: cover property (lvl2 && q.change_enable && ctrl_wr);
	cov_por_flags:   cover property (por_lvl ##1 q.poweron_reset_flag);

endmodule : wrs_watchdog

`default_nettype wire

// ---- verif/tb_wrs_watchdog.sv ----
// self-checking bench for the watchdog and reset-cause block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
	$display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module tb_wrs_watchdog
	import wrs_pkg::*;
;
	logic       sys_clk = 1'b0;
	logic       rst_n   = 1'b0;
	logic [7:0] addr    = 8'h00;
	logic [7:0] wdata   = 8'h00;
	logic       wr      = 1'b0;
	logic       rd      = 1'b0;
	logic [7:0] rdata;
	logic [2:0] osc_div = 3'h0;
	logic [2:0] dets    = 3'h0;
	logic       fuse    = 1'b0;
	logic       restart = 1'b0;
	logic       ack     = 1'b0;
	logic       gie     = 1'b0;
	logic       wdt_reset;
	logic       delay_start;
	logic       timeout_irq;
	int         fails   = 0;
	int         checks  = 0;
	int         n;

	// 4 ns clock
	always #2 sys_clk = ~sys_clk;
	// watchdog oscillator: 8 clocks a period keeps each half above the sync depth
	always @(posedge sys_clk) osc_div <= osc_div + 3'h1;

	wrs_watchdog i_wrs_watchdog (
		.SYS_CLK(sys_clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .WDT_OSC(osc_div[2]), .POR_DET(dets[0]),
		.BOR_DET(dets[1]), .EXT_RST_DET(dets[2]), .SAFETY_FUSE_PROG(fuse),
		.WDT_RESTART(restart), .IRQ_ACK(ack), .GLOBAL_IRQ_EN(gie),
		.WDT_RESET(wdt_reset), .DELAY_START(delay_start), .TIMEOUT_IRQ(timeout_irq)
	);

	task automatic wrr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a; wdata <= d; wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask : wrr

	// read data stand only in the cycle after the strobe
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		addr <= a; rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask : rdc

	// detector held well beyond the sync lag, then released
	task automatic det(input int i);
		@(posedge sys_clk);
		dets[i] <= 1'b1;
		repeat (4) @(posedge sys_clk);
		dets[i] <= 1'b0;
		repeat (5) @(posedge sys_clk);
	endtask : det

	task automatic do_reset();
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
	endtask : do_reset

	task automatic tally_and_finish();
		if (fails == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	// watchdog: about two and a half times the two timeouts the run waits for
	initial begin
		#(4 * 80000);
		fails++;
		tally_and_finish();
	end

	initial begin
		do_reset();
		rdc(WRS_STATUS_ADDR, 8'h01);
		rdc(WRS_CTRL_ADDR, 8'h00);
		rdc(8'h30, 8'h00);
		`CHK(timeout_irq, 1'b0)
		wrr(WRS_STATUS_ADDR, 8'hFF);
		rdc(WRS_STATUS_ADDR, 8'h01);
		wrr(WRS_STATUS_ADDR, 8'h00);
		rdc(WRS_STATUS_ADDR, 8'h00);
		det(1);
		rdc(WRS_STATUS_ADDR, 8'h04);
		det(2);
		rdc(WRS_STATUS_ADDR, 8'h06);
		det(0);
		rdc(WRS_STATUS_ADDR, 8'h01);
		wrr(WRS_CTRL_ADDR, 8'h01);
		rdc(WRS_CTRL_ADDR, 8'h01);
		wrr(WRS_CTRL_ADDR, 8'h00);
		wrr(WRS_STATUS_ADDR, 8'h00);
		// interrupt-first mode: first timeout interrupts, the second resets
		gie <= 1'b1;
		wrr(WRS_CTRL_ADDR, 8'h48);
		for (n = 0; n < 20000 && timeout_irq !== 1'b1; n++) @(negedge sys_clk);
		`CHK(timeout_irq, 1'b1)
		rdc(WRS_CTRL_ADDR, 8'h88);
		@(posedge sys_clk);
		ack <= 1'b1;
		@(posedge sys_clk);
		ack <= 1'b0;
		rdc(WRS_CTRL_ADDR, 8'h08);
		for (n = 0; n < 20000 && wdt_reset !== 1'b1; n++) @(negedge sys_clk);
		`CHK(wdt_reset, 1'b1)
		@(negedge sys_clk);
		`CHK(wdt_reset, 1'b0)
		`CHK(delay_start, 1'b1)
		rdc(WRS_STATUS_ADDR, 8'h08);
		rdc(WRS_CTRL_ADDR, 8'h08);
		wrr(WRS_CTRL_ADDR, 8'h18);
		wrr(WRS_CTRL_ADDR, 8'h00);
		rdc(WRS_CTRL_ADDR, 8'h18);
		wrr(WRS_STATUS_ADDR, 8'h00);
		wrr(WRS_CTRL_ADDR, 8'h18);
		wrr(WRS_CTRL_ADDR, 8'h00);
		rdc(WRS_CTRL_ADDR, 8'h10);
		wrr(WRS_CTRL_ADDR, 8'h08);
		wrr(WRS_CTRL_ADDR, 8'h18);
		rdc(WRS_CTRL_ADDR, 8'h18);
		repeat (5) @(posedge sys_clk);
		rdc(WRS_CTRL_ADDR, 8'h08);
		wrr(WRS_CTRL_ADDR, 8'h00);
		rdc(WRS_CTRL_ADDR, 8'h08);
		// safety level 2: fuse is static, so it changes only across a reset
		fuse <= 1'b1;
		do_reset();
		rdc(WRS_CTRL_ADDR, 8'h08);
		wrr(WRS_CTRL_ADDR, 8'h18);
		wrr(WRS_CTRL_ADDR, 8'h01);
		rdc(WRS_CTRL_ADDR, 8'h19);
		wrr(WRS_CTRL_ADDR, 8'h02);
		rdc(WRS_CTRL_ADDR, 8'h09);
		wrr(WRS_CTRL_ADDR, 8'h18);
		wrr(WRS_CTRL_ADDR, 8'h00);
		rdc(WRS_CTRL_ADDR, 8'h18);
		tally_and_finish();
	end
endmodule : tb_wrs_watchdog
`default_nettype wire
